/* timing_signal_strobe_event_tb_top.sv */
// self-checking bench for the timing-signal unit
module timing_signal_strobe_event_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tsse_pkg::*;
  typedef struct {logic chk; logic [31:0] data; logic err;} tsse_note_s;
  logic clk = 1'b0;
  logic rst_n, psel, penable, pwrite, pps_in, event_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rtc_seconds, q, t, maj;
  logic pready, pslverr, periodic_out, strobe_out, freq_out, irq, rtc_load;
  int n_fail, n_compared, cyc, n, n1, n2;
  int fp[4] = '{CLK_MHZ / FOUT_1_MHZ, CLK_MHZ / FOUT_5_MHZ, CLK_MHZ / FOUT_10_MHZ,
                CLK_MHZ / FOUT_10_MHZ};
  tsse_note_s notes[$];
  tsse_note_s nt;

  always #2 clk = ~clk;

  tsse_top #(.STRB_MAJ_W(22)) DUT (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PPS_IN(pps_in),
    .EVENT_IN(event_in), .PERIODIC_OUT(periodic_out), .STROBE_OUT(strobe_out),
    .FREQ_OUT(freq_out), .IRQ(irq), .RTC_LOAD(rtc_load), .RTC_SECONDS(rtc_seconds));

  tsse_host_model host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // each answer is matched against the oldest note
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      nt = notes.pop_front();
      if (nt.chk) chk(prdata, nt.data);
      chk({31'h0, pslverr}, {31'h0, nt.err});
    end
  end

  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      n_fail++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bus helpers: a note is queued before the transfer starts
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
    notes.push_back('{1'b1, 32'h0, e});
    host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    notes.push_back('{1'b1, e, er});
    host.xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic peek(input logic [7:0] a);
    notes.push_back('{1'b0, 32'h0, 1'b0});
    host.xfer(1'b0, a, 32'h0, t);
  endtask

  // edges sampled until a rise of s, capped at lim
  task automatic rise(ref logic s, input int lim, output int c);
    logic p;
    c = 0;
    p = s;
    while (c < lim && !(p === 1'b0 && s === 1'b1)) begin
      p = s;
      @(posedge clk);
      c++;
    end
  endtask

  task automatic ev_pulse();
    @(posedge clk);
    event_in <= 1'b1;
    repeat (10) @(posedge clk);
    event_in <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    pps_in = 1'b0;
    event_in = 1'b0;
    void'($urandom(82));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_INT_EN, 32'h0, 1'b0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h3c, 32'h1, 1'b1);
    rd(8'h3c, 32'h0, 1'b1);
    // periodic rate after a sync restart, integer rate only
    n1 = 2 + $urandom % 4;
    n2 = 2 + $urandom % 4;
    wr(ADDR_DIV1, 32'(n1), 1'b0);
    wr(ADDR_DIV2, 32'(n2), 1'b0);
    wr(ADDR_CTRL, 32'h1, 1'b0);
    @(posedge clk);
    pps_in <= 1'b1;
    repeat (20) @(posedge clk);
    pps_in <= 1'b0;
    chk({31'h0, periodic_out}, 32'h1);
    rise(periodic_out, 30000, n);
    chk({31'h0, n >= n1 * n2 * TICK_CYC - 20 && n <= n1 * n2 * TICK_CYC - 8}, 32'h1);
    rise(periodic_out, 30000, n);
    chk(32'(n), 32'(n1 * n2 * TICK_CYC));
    // synthesizer at 1 MHz in 1/32 Hz steps
    wr(ADDR_DDS, 32'(US_PER_SEC * DDS_STEPS_HZ), 1'b0);
    wr(ADDR_CTRL, 32'h2, 1'b0);
    rise(periodic_out, 2000, n);
    rise(periodic_out, 2000, n);
    chk(32'(n), 32'(CLK_MHZ));
    wr(ADDR_CTRL, 32'h12, 1'b0);
    wr(ADDR_INT_CLR, 32'h7, 1'b0);
    repeat (600) @(posedge clk);
    rd(ADDR_INT_STAT, 32'h2, 1'b0);
    // falling-edge capture, then lockout and release
    maj = $urandom;
    wr(ADDR_TIME_MAJ, maj, 1'b0);
    wr(ADDR_CTRL, 32'h20, 1'b0);
    wr(ADDR_INT_CLR, 32'h7, 1'b0);
    @(posedge clk);
    event_in <= 1'b1;
    repeat (10) @(posedge clk);
    rd(ADDR_INT_STAT, 32'h0, 1'b0);
    event_in <= 1'b0;
    repeat (10) @(posedge clk);
    rd(ADDR_INT_STAT, 32'h2, 1'b0);
    rd(ADDR_EVT_MAJ, maj, 1'b0);
    wr(ADDR_CTRL, 32'h60, 1'b0);
    wr(ADDR_TIME_MAJ, maj + 32'h1, 1'b0);
    ev_pulse();
    wr(ADDR_TIME_MAJ, maj + 32'h2, 1'b0);
    ev_pulse();
    rd(ADDR_EVT_MAJ, maj + 32'h1, 1'b0);
    wr(ADDR_CMD, 32'h2, 1'b0);
    ev_pulse();
    rd(ADDR_EVT_MAJ, maj + 32'h2, 1'b0);
    // strobe: major mismatch, major match, minor-only with major mismatch
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_TIME_MAJ, maj, 1'b0);
      wr(ADDR_STRB_MAJ, {10'h0, maj[21:0] ^ 22'(m != 1)}, 1'b0);
      wr(ADDR_INT_CLR, 32'h7, 1'b0);
      wr(ADDR_INT_EN, 32'h1, 1'b0);
      peek(ADDR_TIME_MIN);
      wr(ADDR_STRB_MIN, t + 32'h14, 1'b0);
      wr(ADDR_CTRL, (m == 2) ? 32'hc : 32'h4, 1'b0);
      rise(strobe_out, 10000, n);
      chk({31'h0, n < 10000}, {31'h0, m != 0});
      if (m != 0) begin
        n = 0;
        while (strobe_out === 1'b1 && n < 1000) begin
          @(posedge clk);
          n++;
        end
        chk(32'(n), 32'(TICK_CYC));
        chk({31'h0, irq}, 32'h1);
        rise(strobe_out, 1000, n);
        chk(32'(n), 32'(1000));
        wr(ADDR_INT_EN, 32'h0, 1'b0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
      end
      rd(ADDR_INT_STAT, 32'(m != 0), 1'b0);
    end
    // rtc copy of the board seconds
    wr(ADDR_TIME_MAJ, maj, 1'b0);
    wr(ADDR_CMD, 32'h1, 1'b0);
    rise(rtc_load, 4, n);
    chk({31'h0, n < 4}, 32'h1);
    chk(rtc_seconds, maj);
    // every frequency output selection
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'(k) << 8, 1'b0);
      rise(freq_out, 600, n);
      rise(freq_out, 600, n);
      chk(32'(n), 32'(fp[k]));
    end
    // divisor bounds, refused values leave the register alone
    wr(ADDR_DIV1, 32'h1, 1'b1);
    wr(ADDR_DIV1, 32'h1_0000, 1'b1);
    rd(ADDR_DIV1, 32'(n1), 1'b0);
    wr(ADDR_DIV2, 32'hffff, 1'b0);
    rd(ADDR_DIV2, 32'hffff, 1'b0);
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule

/* tsse_host_model.sv */
// apb host model standing in for the software side of the register bus
module tsse_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one transfer: setup, then access held until pready is sampled high
  // software keeps divisors in range except where a refusal is wanted
  // sync mode is only asked for with integer rates
  // strobe major values are given as binary seconds
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // stale data must not look valid
  endtask
endmodule

/* tsse_pkg.sv */
// constants, register map and carriers for the timing-signal unit
package tsse_pkg;
  // clock and time base
  localparam int CLK_NS = 4;
  localparam int CLK_MHZ = 250;
  localparam int CLK_HZ = CLK_MHZ * 1_000_000;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = (TICK_US * 1000) / CLK_NS;
  localparam int US_PER_SEC = 1_000_000;
  localparam int MINOR_W = 20;
  // periodic divider limits
  localparam int DIV_MIN = 2;
  localparam int DIV_LIM = 65536;
  localparam int DIV_W = 16;
  // synthesizer: tuning word in 1/32 Hz steps
  localparam int DDS_STEPS_HZ = 32;
  localparam int DDS_W = 34;
  localparam logic [DDS_W-1:0] DDS_MOD = 34'(CLK_HZ) * 34'(DDS_STEPS_HZ);
  // frequency output dividers
  localparam int FOUT_1_MHZ = 1;
  localparam int FOUT_5_MHZ = 5;
  localparam int FOUT_10_MHZ = 10;
  localparam int FOUT_W = 8;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV1 = 8'h04;
  localparam logic [7:0] ADDR_DIV2 = 8'h08;
  localparam logic [7:0] ADDR_DDS = 8'h0c;
  localparam logic [7:0] ADDR_STRB_MAJ = 8'h10;
  localparam logic [7:0] ADDR_STRB_MIN = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT = 8'h18;
  localparam logic [7:0] ADDR_INT_CLR = 8'h1c;
  localparam logic [7:0] ADDR_INT_EN = 8'h20;
  localparam logic [7:0] ADDR_EVT_MAJ = 8'h24;
  localparam logic [7:0] ADDR_EVT_MIN = 8'h28;
  localparam logic [7:0] ADDR_TIME_MAJ = 8'h2c;
  localparam logic [7:0] ADDR_TIME_MIN = 8'h30;
  localparam logic [7:0] ADDR_CMD = 8'h34;
  // reset values
  localparam logic [DIV_W-1:0] DIV_RST = 16'h000a;
  localparam logic [31:0] DDS_RST = 32'h0000_0000;
  // interrupt and command bit positions
  localparam int INT_STROBE = 0;
  localparam int INT_EVENT = 1;
  localparam int INT_PPS = 2;
  localparam int INT_W = 3;
  localparam int CMD_RTC = 0;
  localparam int CMD_REL = 1;
  typedef enum logic [1:0] {
    FOUT_1M = 2'b00,
    FOUT_5M = 2'b01,
    FOUT_10M = 2'b10
  } tsse_fout_e;
  // control register layout, lsb last
  typedef struct packed {
    tsse_fout_e fout_sel;
    logic spare; // bit 7 unused, keeps the selector at bits 9:8
    logic evt_lock;
    logic evt_fall;
    logic evt_src;
    logic strb_minor;
    logic strb_en;
    logic dds_sel;
    logic ppo_sync;
  } tsse_ctrl_s;
  localparam int CTRL_W = 10;
  localparam tsse_ctrl_s CTRL_RST = '0;
  typedef struct packed {
    logic [31:0] major;
    logic [MINOR_W-1:0] minor;
  } tsse_time_s;
endpackage

/* tsse_top.sv */
// timing-signal unit: periodic, synthesizer, strobe, event capture, apb slave
// How it works
// - periodic rate is 1 MHz over n1 times n2
// - each divisor from 2 to 65535 only
// - sync mode aligns periodic rise to 1PPS
// - control bit puts synthesizer on periodic output
// - synthesizer square wave in 1/32 Hz steps
// - major/minor match gives one 1 us pulse
// - major compare holds 22 bits of seconds
// - minor-only mode strobes once every second
// - strobe and event can raise interrupt
// - event source: external input or periodic output
// - event edge: rising or falling selectable
// - qualifying edge loads current time into capture
// - lockout holds capture until released
// - frequency output selects 1, 5, 10 MHz
// - all interrupts disabled after reset
// - rtc command copies board seconds out
module tsse_top
  import tsse_pkg::*;
#(
  parameter int STRB_MAJ_W = 22
) (
  input logic CLK,
  input logic RST_N,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [7:0] PADDR,
  input logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input logic PPS_IN,
  input logic EVENT_IN,
  output logic PERIODIC_OUT,
  output logic STROBE_OUT,
  output logic FREQ_OUT,
  output logic IRQ,
  output logic RTC_LOAD,
  output logic [31:0] RTC_SECONDS
);

  localparam int SUB_W = $clog2(TICK_CYC);
  localparam int STW = $clog2(TICK_CYC + 1);

  // refuse widths the strobe compare cannot serve
  if (STRB_MAJ_W < 1 || STRB_MAJ_W > 32) begin : g_chk
    $error("STRB_MAJ_W must be 1 to 32");
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and 1PPS edge

  logic pps_s1_ff, pps_s2_ff, pps_d_ff;
  logic evt_s1_ff, evt_s2_ff;
  logic pps_rise;

  // first stage feeds only the second one
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pps_s1_ff <= 1'b0;
      pps_s2_ff <= 1'b0;
      pps_d_ff <= 1'b0;
      evt_s1_ff <= 1'b0;
      evt_s2_ff <= 1'b0;
    end else begin
      pps_s1_ff <= PPS_IN;
      pps_s2_ff <= pps_s1_ff;
      pps_d_ff <= pps_s2_ff;
      evt_s1_ff <= EVENT_IN;
      evt_s2_ff <= evt_s1_ff;
    end
  end

  assign pps_rise = pps_s2_ff & ~pps_d_ff;

  ////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered

  tsse_ctrl_s ctrl_ff;
  logic [DIV_W-1:0] div1_ff, div2_ff;
  logic [31:0] dds_inc_ff;
  logic [STRB_MAJ_W-1:0] strb_maj_ff;
  logic [MINOR_W-1:0] strb_min_ff;
  logic [INT_W-1:0] stat_ff, en_ff, int_set;
  tsse_time_s now_ff, evt_time_ff;
  logic pready_ff, pslverr_ff, irq_ff;
  logic [31:0] prdata_ff, rd_val;
  logic rd_ok, ro_hit, div_bad, wr_ok, acc;

  // read mux; write-only registers read as zero
  always_comb begin
    rd_val = '0;
    rd_ok = 1'b1;
    ro_hit = 1'b0;
    case (PADDR)
      ADDR_CTRL: rd_val = 32'(ctrl_ff);
      ADDR_DIV1: rd_val = 32'(div1_ff);
      ADDR_DIV2: rd_val = 32'(div2_ff);
      ADDR_DDS: rd_val = dds_inc_ff;
      ADDR_STRB_MAJ: rd_val = 32'(strb_maj_ff);
      ADDR_STRB_MIN: rd_val = 32'(strb_min_ff);
      ADDR_INT_STAT: begin
        rd_val = 32'(stat_ff);
        ro_hit = 1'b1;
      end
      ADDR_INT_CLR: rd_val = '0;
      ADDR_INT_EN: rd_val = 32'(en_ff);
      ADDR_EVT_MAJ: begin
        rd_val = evt_time_ff.major;
        ro_hit = 1'b1;
      end
      ADDR_EVT_MIN: begin
        rd_val = 32'(evt_time_ff.minor);
        ro_hit = 1'b1;
      end
      ADDR_TIME_MAJ: rd_val = now_ff.major;
      ADDR_TIME_MIN: begin
        rd_val = 32'(now_ff.minor);
        ro_hit = 1'b1;
      end
      ADDR_CMD: rd_val = '0;
      default: rd_ok = 1'b0;
    endcase
  end

  // out-of-range divisors are refused, old value kept
  assign div_bad = (PADDR == ADDR_DIV1 || PADDR == ADDR_DIV2) &&
                   (PWDATA < 32'(DIV_MIN) || PWDATA >= 32'(DIV_LIM));
  assign acc = PSEL & PENABLE;
  // error decided in the wait cycle, so it gates the write edge
  assign wr_ok = acc & pready_ff & PWRITE & ~pslverr_ff;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc & ~pready_ff;
      if (acc && !pready_ff) begin
        prdata_ff <= PWRITE ? 32'h0000_0000 : rd_val;
        pslverr_ff <= ~rd_ok | (PWRITE & (ro_hit | div_bad));
      end else begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_ff <= CTRL_RST;
      div1_ff <= DIV_RST;
      div2_ff <= DIV_RST;
      dds_inc_ff <= DDS_RST;
      strb_maj_ff <= '0;
      strb_min_ff <= '0;
      en_ff <= '0;
    end else if (wr_ok) begin
      case (PADDR)
        ADDR_CTRL: ctrl_ff <= tsse_ctrl_s'(PWDATA[CTRL_W-1:0]);
        ADDR_DIV1: div1_ff <= PWDATA[DIV_W-1:0];
        ADDR_DIV2: div2_ff <= PWDATA[DIV_W-1:0];
        ADDR_DDS: dds_inc_ff <= PWDATA;
        ADDR_STRB_MAJ: strb_maj_ff <= PWDATA[STRB_MAJ_W-1:0];
        ADDR_STRB_MIN: strb_min_ff <= PWDATA[MINOR_W-1:0];
        ADDR_INT_EN: en_ff <= PWDATA[INT_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // board time: microsecond tick, minor and major count

  logic [SUB_W-1:0] sub_ff;
  logic tick, tick_d_ff;

  assign tick = sub_ff == SUB_W'(TICK_CYC - 1);

  // 1PPS restarts the tick so microseconds line up with the epoch
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sub_ff <= '0;
      tick_d_ff <= 1'b0;
    end else begin
      tick_d_ff <= tick;
      if (pps_rise || tick) begin
        sub_ff <= '0;
      end else begin
        sub_ff <= sub_ff + SUB_W'(1);
      end
    end
  end

  // an epoch just after a local rollover does not count the second twice
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      now_ff <= '0;
    end else begin
      if (pps_rise) begin
        now_ff.minor <= '0;
        if (now_ff.minor >= MINOR_W'(US_PER_SEC / 2)) begin
          now_ff.major <= now_ff.major + 32'h1;
        end
      end else if (tick) begin
        if (now_ff.minor == MINOR_W'(US_PER_SEC - 1)) begin
          now_ff.minor <= '0;
          now_ff.major <= now_ff.major + 32'h1;
        end else begin
          now_ff.minor <= now_ff.minor + MINOR_W'(1);
        end
      end
      if (wr_ok && PADDR == ADDR_TIME_MAJ) begin
        now_ff.major <= PWDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // periodic pulse output: two cascaded dividers on the 1 us tick

  logic [DIV_W-1:0] c1_ff, c2_ff, nxt_c2;
  logic ppo_ff;

  assign nxt_c2 = (c2_ff == div2_ff - DIV_W'(1)) ? '0 : c2_ff + DIV_W'(1);

  // high for the first half of each n2 period, so the rise marks a cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      c1_ff <= '0;
      c2_ff <= '0;
      ppo_ff <= 1'b0;
    end else if (pps_rise && ctrl_ff.ppo_sync) begin
      c1_ff <= '0;
      c2_ff <= '0;
      ppo_ff <= 1'b1;
    end else if (tick) begin
      if (c1_ff == div1_ff - DIV_W'(1)) begin
        c1_ff <= '0;
        c2_ff <= nxt_c2;
        ppo_ff <= nxt_c2 < (div2_ff >> 1);
      end else begin
        c1_ff <= c1_ff + DIV_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synthesizer: modulo accumulator, modulus is clock rate times 32

  logic [DDS_W-1:0] acc_ff, acc_sum;
  logic dds_ff, per_out_ff;

  assign acc_sum = acc_ff + DDS_W'(dds_inc_ff);

  // non-binary modulus keeps the step exactly 1/32 Hz
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_ff <= '0;
      dds_ff <= 1'b0;
    end else begin
      acc_ff <= (acc_sum >= DDS_MOD) ? acc_sum - DDS_MOD : acc_sum;
      dds_ff <= acc_ff < (DDS_MOD >> 1);
    end
  end

  // output select
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_out_ff <= 1'b0;
    end else begin
      per_out_ff <= ctrl_ff.dds_sel ? dds_ff : ppo_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time-coincidence strobe

  logic strb_hit, strobe_ff;
  logic [STW-1:0] strb_w_ff;

  // compared only in the cycle after a tick, once per time value
  assign strb_hit = ctrl_ff.strb_en & tick_d_ff &
                    (now_ff.minor == strb_min_ff) &
                    (ctrl_ff.strb_minor |
                     (now_ff.major[STRB_MAJ_W-1:0] == strb_maj_ff));

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strb_w_ff <= '0;
      strobe_ff <= 1'b0;
    end else if (strb_hit) begin
      strb_w_ff <= STW'(TICK_CYC);
      strobe_ff <= 1'b1;
    end else begin
      if (strb_w_ff != '0) begin
        strb_w_ff <= strb_w_ff - STW'(1);
      end
      strobe_ff <= strb_w_ff > STW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event capture

  logic src_lvl, src_d_ff, evt_edge, capture, locked_ff, release_cmd;

  assign src_lvl = ctrl_ff.evt_src ? per_out_ff : evt_s2_ff;
  assign evt_edge = ctrl_ff.evt_fall ? (src_d_ff & ~src_lvl) :
                                       (~src_d_ff & src_lvl);
  assign capture = evt_edge & ~locked_ff;
  assign release_cmd = wr_ok && PADDR == ADDR_CMD && PWDATA[CMD_REL];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      src_d_ff <= 1'b0;
      evt_time_ff <= '0;
    end else begin
      src_d_ff <= src_lvl;
      if (capture) begin
        evt_time_ff <= now_ff;
      end
    end
  end

  // a capture in the release cycle locks again
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      locked_ff <= 1'b0;
    end else if (capture && ctrl_ff.evt_lock) begin
      locked_ff <= 1'b1;
    end else if (release_cmd || !ctrl_ff.evt_lock) begin
      locked_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frequency output divider

  logic [FOUT_W-1:0] fdiv, fcnt_ff;
  logic fout_ff;

  always_comb begin
    case (ctrl_ff.fout_sel)
      FOUT_1M: fdiv = FOUT_W'(CLK_MHZ / FOUT_1_MHZ);
      FOUT_5M: fdiv = FOUT_W'(CLK_MHZ / FOUT_5_MHZ);
      FOUT_10M: fdiv = FOUT_W'(CLK_MHZ / FOUT_10_MHZ);
      default: fdiv = FOUT_W'(CLK_MHZ / FOUT_10_MHZ);
    endcase
  end

  // odd divisors give a duty a cycle off half; the rate is exact
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fcnt_ff <= '0;
      fout_ff <= 1'b0;
    end else begin
      fcnt_ff <= (fcnt_ff >= fdiv - FOUT_W'(1)) ? '0 : fcnt_ff + FOUT_W'(1);
      fout_ff <= fcnt_ff < (fdiv >> 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupts and rtc sync

  logic rtc_load_ff;
  logic [31:0] rtc_sec_ff;

  assign int_set[INT_STROBE] = strb_hit;
  assign int_set[INT_EVENT] = capture;
  assign int_set[INT_PPS] = pps_rise;

  // set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_ok && PADDR == ADDR_INT_CLR) begin
        stat_ff <= (stat_ff & ~PWDATA[INT_W-1:0]) | int_set;
      end else begin
        stat_ff <= stat_ff | int_set;
      end
      irq_ff <= |(stat_ff & en_ff);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rtc_load_ff <= 1'b0;
      rtc_sec_ff <= '0;
    end else begin
      rtc_load_ff <= wr_ok && PADDR == ADDR_CMD && PWDATA[CMD_RTC];
      if (wr_ok && PADDR == ADDR_CMD && PWDATA[CMD_RTC]) begin
        rtc_sec_ff <= now_ff.major;
      end
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign PERIODIC_OUT = per_out_ff;
  assign STROBE_OUT = strobe_ff;
  assign FREQ_OUT = fout_ff;
  assign IRQ = irq_ff;
  assign RTC_LOAD = rtc_load_ff;
  assign RTC_SECONDS = rtc_sec_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic [STW:0] hi_len_ff;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_len_ff <= '0;
    end else begin
      hi_len_ff <= STROBE_OUT ? hi_len_ff + (STW + 1)'(1) : '0;
    end
  end

  sequence rtc_req_s;
    wr_ok && PADDR == ADDR_CMD && PWDATA[CMD_RTC];
  endsequence

  sequence sync_epoch_s;
    pps_rise && ctrl_ff.ppo_sync;
  endsequence

  div_range_a: assert property (div1_ff >= DIV_W'(DIV_MIN) &&
    div2_ff >= DIV_W'(DIV_MIN)) else $error("divisor below two");
  ppo_sync_a: assert property (sync_epoch_s |=> ppo_ff && c2_ff == '0)
    else $error("periodic not aligned to epoch");
  ppo_sel_a: assert property (##1 per_out_ff ==
    $past(ctrl_ff.dds_sel ? dds_ff : ppo_ff)) else $error("periodic select wrong");
  strobe_width_a: assert property ($fell(STROBE_OUT) |->
    hi_len_ff == (STW + 1)'(TICK_CYC)) else $error("strobe not one microsecond");
  strobe_cause_a: assert property ($rose(STROBE_OUT) |-> $past(strb_hit))
    else $error("strobe without match");
  event_lock_a: assert property (locked_ff && ctrl_ff.evt_lock |=>
    $stable(evt_time_ff)) else $error("locked capture changed");
  capture_time_a: assert property (capture |=>
    evt_time_ff == $past(now_ff)) else $error("capture time wrong");
  irq_gate_a: assert property ($rose(IRQ) |-> $past(|(stat_ff & en_ff)))
    else $error("interrupt without enabled source");
  rtc_copy_a: assert property (rtc_req_s |=> RTC_LOAD &&
    RTC_SECONDS == $past(now_ff.major)) else $error("rtc copy wrong");
  stat_set_a: assert property (strb_hit |=> stat_ff[INT_STROBE])
    else $error("strobe status lost");

endmodule
